// File: rtl/adsc_ctrl.v
`timescale 1ns/1ps
`include "adsc_regs.vh"
module adsc_ctrl (
  input  wire        core_clk_i,
  input  wire        resetn_i,
  input  wire        clk_en_i,
  // avalon-mm slave
  input  wire [5:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // converter side (same clock)
  input  wire        sw_start_i,
  input  wire        seq_done_i,
  input  wire [8:0]  dma_upd_req_i,
  output wire [8:0]  dma_upd_grant_o,
  output reg         conv_start_o,
  output wire        event_start_enable_o,
  // event trigger from outside the clock domain
  input  wire        evt_start_i
);
  reg  [31:0] seq_ctrl_r;
  reg         evt_cfg_r;
  reg         ack_r;
  reg         seq_seen_r;
  reg         trig_seen_r;
  reg         evt_d_r;
  wire        evt_sync;
  wire        evt_rise;
  wire        launch;
  wire        hit_ctrl;
  wire        hit_evt;
  wire        hit_stat;
  wire [31:0] be_mask;
  reg         seq_seen_nxt;
  reg         trig_seen_nxt;
  reg         start_nxt;

  // byte enables expanded to bit mask
  function [31:0] be_expand;
    input [3:0] be;
    begin
      be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  adsc_sync2 #(.W(1)) u_evt_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .clk_en_i   (clk_en_i),
    .d_i        (evt_start_i),
    .q_o        (evt_sync)
  );

  assign be_mask  = be_expand(avs_byteenable_i);
  assign hit_ctrl = (avs_address_i == `ADSC_SEQ_CTRL_OFS);
  assign hit_evt  = (avs_address_i == `ADSC_EVT_CFG_OFS);
  assign hit_stat = (avs_address_i == `ADSC_STATUS_OFS);
  // one wait cycle per access, released by ack
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign event_start_enable_o = evt_cfg_r;
  assign evt_rise = evt_sync & ~evt_d_r;
  // event start enabled overrides auto launch
  assign launch = seq_ctrl_r[`ADSC_LAUNCH_BIT] & ~evt_cfg_r;

  // dma update gating per register
  assign dma_upd_grant_o[8] = dma_upd_req_i[8] & seq_ctrl_r[`ADSC_OFFSET_BIT];
  assign dma_upd_grant_o[7] = dma_upd_req_i[7] & seq_ctrl_r[`ADSC_GAIN_BIT];
  assign dma_upd_grant_o[6:0] = dma_upd_req_i[6:0] & seq_ctrl_r[6:0];

  // register writes and read answer
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_ctrl_r     <= `ADSC_SEQ_CTRL_RST;
      evt_cfg_r      <= 1'b0;
      ack_r          <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
      if (avs_write_i && ack_r && hit_ctrl) begin
        seq_ctrl_r <= ((seq_ctrl_r & ~be_mask) | (avs_writedata_i & be_mask)) & `ADSC_SEQ_CTRL_MASK;
      end
      if (avs_write_i && ack_r && hit_evt && avs_byteenable_i[0]) begin
        evt_cfg_r <= avs_writedata_i[`ADSC_EVT_START_BIT];
      end
      if (avs_read_i && !ack_r) begin
        // unmapped addresses read as zero
        if (hit_ctrl) begin
          avs_readdata_o <= seq_ctrl_r;
        end else if (hit_evt) begin
          avs_readdata_o <= {31'h00000000, evt_cfg_r};
        end else if (hit_stat) begin
          avs_readdata_o <= {29'h00000000, seq_seen_r, trig_seen_r, conv_start_o};
        end else begin
          avs_readdata_o <= 32'h00000000;
        end
      end
    end
  end

  // start decision; pending sequence and trigger are sticky until used
  always @* begin
    seq_seen_nxt  = seq_seen_r | seq_done_i;
    trig_seen_nxt = trig_seen_r | sw_start_i | (evt_cfg_r & evt_rise);
    start_nxt     = 1'b0;
    if (launch && seq_done_i) begin
      start_nxt    = 1'b1;
      seq_seen_nxt = 1'b0;
    end else if (!launch && seq_seen_nxt && trig_seen_nxt) begin
      start_nxt     = 1'b1;
      seq_seen_nxt  = 1'b0;
      trig_seen_nxt = 1'b0;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_seen_r   <= 1'b0;
      trig_seen_r  <= 1'b0;
      conv_start_o <= 1'b0;
      evt_d_r      <= 1'b0;
    end else if (clk_en_i) begin
      seq_seen_r   <= seq_seen_nxt;
      trig_seen_r  <= trig_seen_nxt;
      conv_start_o <= start_nxt;
      evt_d_r      <= evt_sync;
    end
  end
endmodule // adsc_ctrl

// File: rtl/adsc_regs.vh
`ifndef ADSC_REGS_VH
`define ADSC_REGS_VH
// register map
`define ADSC_SEQ_CTRL_OFS    6'h38
`define ADSC_EVT_CFG_OFS     6'h3C
`define ADSC_STATUS_OFS      6'h30
`define ADSC_SEQ_CTRL_RST    32'h00000000
`define ADSC_SEQ_CTRL_MASK   32'h800001FF
// dma_sequence_control fields
`define ADSC_LAUNCH_BIT      31
`define ADSC_OFFSET_BIT      8
`define ADSC_GAIN_BIT        7
`define ADSC_UPD_W           9
// event_configuration field
`define ADSC_EVT_START_BIT   0
// status fields
`define ADSC_ST_PEND_BIT     0
`define ADSC_ST_TRIG_BIT     1
`define ADSC_ST_SEQ_BIT      2
`endif

// File: rtl/adsc_sync2.v
`timescale 1ns/1ps
// two-stage synchroniser for pin-side levels
module adsc_sync2 #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         resetn_i,
  input  wire         clk_en_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // first stage only feeds the second
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else if (clk_en_i) begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule // adsc_sync2

// File: tb/adsc_monitor.sv
`timescale 1ns/1ps
module adsc_monitor (input wire core_clk_i, input wire resetn_i, input wire [5:0] avs_address_i,
  input wire avs_write_i, input wire [31:0] avs_writedata_i, input wire avs_waitrequest_o,
  input wire sw_start_i, input wire seq_done_i, input wire [8:0] dma_upd_req_i,
  input wire [8:0] dma_upd_grant_o, input wire conv_start_o, input wire event_start_enable_o,
  input wire evt_start_i);
  reg [9:0] sh_r;
  // shadow of the enables, taken only when a write completes
  always @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i) sh_r <= 10'h000;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 6'h38)
      sh_r <= {avs_writedata_i[31], avs_writedata_i[8:0]};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_offset_grant: assert property (dma_upd_grant_o[8] == (dma_upd_req_i[8] & sh_r[8]))
    else $error("offset grant wrong");
  a_gain_grant: assert property (dma_upd_grant_o[7] == (dma_upd_req_i[7] & sh_r[7]))
    else $error("gain grant wrong");
  a_low_grants: assert property (dma_upd_grant_o[6:0] == (dma_upd_req_i[6:0] & sh_r[6:0]))
    else $error("low grants wrong");
  a_auto_launch: assert property (sh_r[9] && !event_start_enable_o && seq_done_i |=> conv_start_o)
    else $error("no start after sequence");
  a_start_cause: assert property ($rose(conv_start_o) |-> $past(seq_done_i | sw_start_i | evt_start_i)
    || $past(sw_start_i, 2)) else $error("start without cause");
  a_event_path: assert property (event_start_enable_o && seq_done_i && !sw_start_i && !evt_start_i
    |=> !conv_start_o) else $error("start ignored event path");
endmodule // adsc_monitor
bind adsc_ctrl adsc_monitor mon (.core_clk_i, .resetn_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
  .avs_waitrequest_o, .sw_start_i, .seq_done_i, .dma_upd_req_i, .dma_upd_grant_o, .conv_start_o,
  .event_start_enable_o, .evt_start_i);

// File: tb/adsc_dma_model.sv
`timescale 1ns/1ps
module adsc_dma_model (input wire core_clk_i, input wire resetn_i, input wire go_i,
  output logic [8:0] req_o, output logic done_o);
  int n;
  // random register updates, then a one-cycle done pulse
  always @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i) begin n <= 0; req_o <= 9'h000; done_o <= 1'b0; end
    else begin
      n <= go_i ? 8 : (n > 0 ? n - 1 : 0);
      req_o <= n > 1 ? 9'($urandom) : 9'h000;
      done_o <= n == 1;
    end
endmodule // adsc_dma_model

// File: tb/adc_dma_sequence_control_bench.sv
`timescale 1ns/1ps
module adc_dma_sequence_control_bench;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, sw = 0, go = 0, ev = 0, en = 1, s, done, cs, wt, ee;
  logic [5:0] a = 0;
  logic [31:0] wd = 0, rdat, v, x;
  logic [8:0] req, gnt;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  always #25 clk = ~clk;
  adsc_ctrl dut (.core_clk_i(clk), .resetn_i(rstn), .clk_en_i(en), .avs_address_i(a), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .sw_start_i(sw), .seq_done_i(done), .dma_upd_req_i(req),
    .dma_upd_grant_o(gnt), .conv_start_o(cs), .event_start_enable_o(ee), .evt_start_i(ev));
  adsc_dma_model dma (.core_clk_i(clk), .resetn_i(rstn), .go_i(go), .req_o(req), .done_o(done));
  task chk(string n, logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end
  endtask
  // hold the request until waitrequest is sampled low at a rising edge
  task bus(logic w, logic [5:0] ad, logic [31:0] d);
    wr <= w; rd <= !w; a <= ad; wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    v = rdat; wr <= 0; rd <= 0;
    // one idle edge so the next call never re-raises in this time step
    @(posedge clk);
  endtask
  task burst;
    go <= 1; @(posedge clk); go <= 0;
    repeat (12) begin @(negedge clk); chk("grant", req & x[8:0], gnt); if (done) break; end
  endtask
  task seen(string n, logic e, int k);
    s = 0; repeat (k) begin @(negedge clk); s |= cs; end
    chk(n, e, s); @(posedge clk);
  endtask
  // cut a hang short
  always @(posedge clk) if (++cyc > 3000) begin error_cnt++; print_verdict; end
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    x = $urandom(5438);
    repeat (4) @(posedge clk); rstn <= 1; @(posedge clk);
    bus(0, 6'h38, 0); chk("ctrl reset", 0, v);
    bus(0, 6'h14, 0); chk("unmapped", 0, v);
    repeat (6) begin
      x = $urandom | 32'h80000000; bus(1, 6'h38, x); bus(0, 6'h38, 0);
      chk("ctrl", x & 32'h800001FF, v);
      burst; seen("auto", 1, 2);
    end
    x = 0; bus(1, 6'h38, x); burst; seen("held", 0, 3);
    bus(0, 6'h30, 0); chk("status", 32'h4, v);
    // frozen clock enable must swallow a trigger pulse
    en <= 0; sw <= 1; @(posedge clk); sw <= 0; @(posedge clk); en <= 1;
    seen("frozen", 0, 3);
    sw <= 1; @(posedge clk); sw <= 0; seen("sw", 1, 3);
    x = 32'h800001FF; bus(1, 6'h38, x); bus(1, 6'h3C, 1); chk("ev en", 1, ee);
    bus(0, 6'h3C, 0); chk("ev cfg", 1, v);
    burst; seen("ev held", 0, 3);
    ev <= 1; seen("ev", 1, 8);
    print_verdict;
  end
endmodule // adc_dma_sequence_control_bench
